// *** shared/usbe_consts.svh ***
`ifndef USBE_CONSTS_SVH
`define USBE_CONSTS_SVH

`define USBE_OFF_EP1_RX 8'h00
`define USBE_OFF_EP1_TX 8'h04
`define USBE_OFF_EP2_RX 8'h08
`define USBE_OFF_EP2_TX 8'h0C
`define USBE_OFF_CTRL 8'h10

`define USBE_SEL_EP1_RX 2'h0
`define USBE_SEL_EP1_TX 2'h1
`define USBE_SEL_EP2_RX 2'h2
`define USBE_SEL_EP2_TX 2'h3

`define USBE_BIT_FLAG 3
`define USBE_BIT_SEQ 2
`define USBE_BIT_FORCED_BUS_RESET 0
`define USBE_MODE_HI 7
`define USBE_MODE_LO 6

`define USBE_STAT_DIS 2'h0
`define USBE_STAT_STALL 2'h1
`define USBE_STAT_NAK 2'h2
`define USBE_STAT_VALID 2'h3

`define USBE_MODE_NORMAL 2'h0
`define USBE_MODE_UPLOAD 2'h1
`define USBE_MODE_DOWNLOAD 2'h2

`define USBE_RESET_BYTE 8'h00
`define USBE_RESP_OKAY 2'h0
`define USBE_RESP_SLVERR 2'h2

`endif

// *** shared/usbe_pkg.sv ***
package usbe_pkg;
  typedef logic [7:0] usbe_byte_t;
  typedef logic [1:0] usbe_stat_t;
  typedef struct packed {
    logic done;
    logic seq;
    usbe_stat_t stat;
  } usbe_field_t;
endpackage

// *** shared/usbe_reg_if.sv ***
`timescale 1ns/1ns
interface usbe_reg_if;
  import usbe_pkg::*;
  logic reg_wr;
  logic [1:0] reg_wsel;
  usbe_byte_t reg_wdata;
  logic [1:0] reg_rsel;
  usbe_byte_t reg_rdata;
  logic forced_bus_reset;
  modport dev (
    input reg_wr,
    input reg_wsel,
    input reg_wdata,
    input reg_rsel,
    input forced_bus_reset,
    output reg_rdata
  );
  modport ctl (
    output reg_wr,
    output reg_wsel,
    output reg_wdata,
    output reg_rsel,
    output forced_bus_reset,
    input reg_rdata
  );
endinterface

// *** core/usbe_dir_ctl.sv ***
`timescale 1ns/1ns
`include "usbe_consts.svh"
module usbe_dir_ctl
  import usbe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bus_rst,
  input wire logic sw_wr,
  input wire logic [3:0] sw_data,
  input wire logic stat_lock,
  input wire logic flag_set,
  input wire logic seq_flip,
  input wire logic to_nak,
  input wire logic to_valid,
  output usbe_field_t field
);
  logic done_reg;
  logic seq_reg;
  usbe_stat_t stat_reg;

  // Done flag: set wins over software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_reg <= 1'b0;
    end else if (flag_set) begin
      done_reg <= 1'b1;
    end else if (sw_wr) begin
      done_reg <= done_reg & sw_data[`USBE_BIT_FLAG];
    end
  end

  // Sequence bit: hardware flip, else software write
  always_ff @(posedge aclk) begin
    if (!aresetn || bus_rst) begin
      seq_reg <= 1'b0;
    end else if (seq_flip) begin
      seq_reg <= ~seq_reg;
    end else if (sw_wr) begin
      seq_reg <= sw_data[`USBE_BIT_SEQ];
    end
  end

  // Handshake status
  always_ff @(posedge aclk) begin
    if (!aresetn || bus_rst) begin
      stat_reg <= `USBE_STAT_DIS;
    end else if (to_nak) begin
      stat_reg <= `USBE_STAT_NAK;
    end else if (to_valid) begin
      stat_reg <= `USBE_STAT_VALID;
    end else if (sw_wr && !stat_lock) begin
      stat_reg <= sw_data[1:0];
    end
  end

  assign field = '{done: done_reg, seq: seq_reg, stat: stat_reg};
endmodule

// *** core/usbe_endpoint_dev.sv ***
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "usbe_consts.svh"
// Operation
// - USB reset clears sequence and status bits
// - Endpoint 1 receive upper nibble reads zero
// - Good reception sets receive done flag
// - Receive sequence flips on matching good packet
// - Receive status: off, stall, NAK, valid
// - Good reception forces receive status NAK
// - Good transmission sets transmit done flag
// - Transmit sequence flips on host ACK
// - Software writes to sequence bits take effect
// - Transmit status: off, stall, NAK, valid
// - Good transmission forces transmit status NAK
// - Endpoint 2 mode field in top bits
// - Software preloads receive side before download
// - Software preloads transmit side before upload
// - Download: hardware OUT, no flag, auto valid
// - Download: IN handled as normal
// - Short download packet ends mode, flags, NAK
// - Upload: OUT normal, IN by hardware
// - Download locks endpoint 2 receive status
// - Endpoint 2 receive bits 5:4 read zero
// - Upload locks endpoint 2 transmit status
module usbe_endpoint_dev
  import usbe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  usbe_reg_if.dev regs,
  input wire logic bus_reset_in,
  input wire logic evt_valid,
  input wire logic [1:0] evt_ep,
  input wire logic evt_in,
  input wire logic evt_ok,
  input wire logic evt_data1,
  input wire logic evt_ack,
  input wire logic evt_short,
  input wire logic buf_rx_ready,
  input wire logic buf_tx_ready,
  output usbe_field_t ep1_rx_field,
  output usbe_field_t ep1_tx_field,
  output usbe_field_t ep2_rx_field,
  output usbe_field_t ep2_tx_field,
  output logic [1:0] ep2_mode
);
  logic bus_rst;
  logic [1:0] mode_reg;
  logic dl_mode;
  logic ul_mode;
  logic [3:0] wr_hit;
  logic ep1_rx_done;
  logic ep1_tx_done;
  logic ep2_rx_done;
  logic ep2_tx_done;
  logic ep2_rx_short;
  logic ep2_tx_short;
  logic ep2_rx_flag;
  logic ep2_tx_flag;
  logic ep2_rx_valid;
  logic ep2_tx_valid;
  logic out_good;
  logic in_acked;
  usbe_byte_t rdata;

  function automatic logic rx_ok(input logic hit, input logic pid, input logic [1:0] num,
    input logic [1:0] ep, input usbe_field_t f);
    rx_ok = hit && num == ep && pid == f.seq && f.stat == `USBE_STAT_VALID;
  endfunction

  function automatic logic tx_ok(input logic hit, input logic [1:0] num, input logic [1:0] ep,
    input usbe_field_t f);
    tx_ok = hit && num == ep && f.stat == `USBE_STAT_VALID;
  endfunction

  function automatic usbe_byte_t low_field(input usbe_field_t f);
    low_field = {4'h0, f};
  endfunction

  // USB reset, received or forced
  assign bus_rst = bus_reset_in | regs.forced_bus_reset;

  // Bus event qualifiers
  assign out_good = evt_valid && evt_ok && !evt_in;
  assign in_acked = evt_valid && evt_ack && evt_in;

  // Mode decode, value 3 treated as normal
  always_comb begin
    dl_mode = 1'b0;
    ul_mode = 1'b0;
    case (mode_reg)
      `USBE_MODE_DOWNLOAD: dl_mode = 1'b1;
      `USBE_MODE_UPLOAD: ul_mode = 1'b1;
      default: begin
        dl_mode = 1'b0;
        ul_mode = 1'b0;
      end
    endcase
  end

  // Transfer completion per endpoint and direction
  always_comb begin
    ep1_rx_done = rx_ok(out_good, evt_data1, evt_ep, 2'h1, ep1_rx_field);
    ep1_tx_done = tx_ok(in_acked, evt_ep, 2'h1, ep1_tx_field);
    ep2_rx_done = rx_ok(out_good, evt_data1, evt_ep, 2'h2, ep2_rx_field);
    ep2_tx_done = tx_ok(in_acked, evt_ep, 2'h2, ep2_tx_field);
    ep2_rx_short = ep2_rx_done && dl_mode && evt_short;
    ep2_tx_short = ep2_tx_done && ul_mode && evt_short;
  end

  // Hardware-managed directions raise no flag except on short packet
  assign ep2_rx_flag = ep2_rx_done && (!dl_mode || evt_short);
  assign ep2_tx_flag = ep2_tx_done && (!ul_mode || evt_short);

  // Re-arm when the buffer can take or give data
  assign ep2_rx_valid = dl_mode && buf_rx_ready && !ep2_rx_short;
  assign ep2_tx_valid = ul_mode && buf_tx_ready && !ep2_tx_short;

  // Write decode
  always_comb begin
    wr_hit = 4'h0;
    if (regs.reg_wr) begin
      wr_hit[regs.reg_wsel] = 1'b1;
    end
  end

  // Endpoint 2 mode, software owned, hardware exit on short packet
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= `USBE_MODE_NORMAL;
    end else if (ep2_rx_short || ep2_tx_short) begin
      mode_reg <= `USBE_MODE_NORMAL;
    end else if (wr_hit[`USBE_SEL_EP2_RX]) begin
      mode_reg <= regs.reg_wdata[`USBE_MODE_HI:`USBE_MODE_LO];
    end
  end

  usbe_dir_ctl u_ep1_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus_rst(bus_rst),
    .sw_wr(wr_hit[`USBE_SEL_EP1_RX]),
    .sw_data(regs.reg_wdata[3:0]),
    .stat_lock(1'b0),
    .flag_set(ep1_rx_done),
    .seq_flip(ep1_rx_done),
    .to_nak(ep1_rx_done),
    .to_valid(1'b0),
    .field(ep1_rx_field)
  );

  usbe_dir_ctl u_ep1_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus_rst(bus_rst),
    .sw_wr(wr_hit[`USBE_SEL_EP1_TX]),
    .sw_data(regs.reg_wdata[3:0]),
    .stat_lock(1'b0),
    .flag_set(ep1_tx_done),
    .seq_flip(ep1_tx_done),
    .to_nak(ep1_tx_done),
    .to_valid(1'b0),
    .field(ep1_tx_field)
  );

  usbe_dir_ctl u_ep2_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus_rst(bus_rst),
    .sw_wr(wr_hit[`USBE_SEL_EP2_RX]),
    .sw_data(regs.reg_wdata[3:0]),
    .stat_lock(dl_mode),
    .flag_set(ep2_rx_flag),
    .seq_flip(ep2_rx_done),
    .to_nak(ep2_rx_done),
    .to_valid(ep2_rx_valid),
    .field(ep2_rx_field)
  );

  usbe_dir_ctl u_ep2_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus_rst(bus_rst),
    .sw_wr(wr_hit[`USBE_SEL_EP2_TX]),
    .sw_data(regs.reg_wdata[3:0]),
    .stat_lock(ul_mode),
    .flag_set(ep2_tx_flag),
    .seq_flip(ep2_tx_done),
    .to_nak(ep2_tx_done),
    .to_valid(ep2_tx_valid),
    .field(ep2_tx_field)
  );

  // Read-back mux
  always_comb begin
    case (regs.reg_rsel)
      `USBE_SEL_EP1_RX: rdata = low_field(ep1_rx_field);
      `USBE_SEL_EP1_TX: rdata = low_field(ep1_tx_field);
      `USBE_SEL_EP2_RX: rdata = {mode_reg, 2'h0, ep2_rx_field};
      `USBE_SEL_EP2_TX: rdata = low_field(ep2_tx_field);
      default: rdata = `USBE_RESET_BYTE;
    endcase
  end

  assign regs.reg_rdata = rdata;
  assign ep2_mode = mode_reg;
endmodule

// *** core/usbe_sw_ctl.sv ***
`timescale 1ns/1ns
`include "usbe_consts.svh"
module usbe_sw_ctl
  import usbe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  usbe_reg_if.ctl regs,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [7:0] wbyte_reg;
  logic wlane_reg;
  logic forced_bus_reset_reg;
  logic do_write;
  logic [7:0] araddr_reg;
  logic rd_pend_reg;
  logic [2:0] wdec;

  function automatic logic [2:0] decode(input logic [7:0] a);
    case (a)
      `USBE_OFF_EP1_RX: decode = {1'b1, `USBE_SEL_EP1_RX};
      `USBE_OFF_EP1_TX: decode = {1'b1, `USBE_SEL_EP1_TX};
      `USBE_OFF_EP2_RX: decode = {1'b1, `USBE_SEL_EP2_RX};
      `USBE_OFF_EP2_TX: decode = {1'b1, `USBE_SEL_EP2_TX};
      default: decode = 3'h0;
    endcase
  endfunction

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  // Write address and data captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wbyte_reg <= `USBE_RESET_BYTE;
      wlane_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wbyte_reg <= s_axi_wdata[7:0];
      wlane_reg <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // Forced bus reset bit, held until software clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      forced_bus_reset_reg <= 1'b0;
    end else if (do_write && wlane_reg && awaddr_reg == `USBE_OFF_CTRL) begin
      forced_bus_reset_reg <= wbyte_reg[`USBE_BIT_FORCED_BUS_RESET];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `USBE_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (decode(awaddr_reg) != 3'h0 || awaddr_reg == `USBE_OFF_CTRL)
        ? `USBE_RESP_OKAY : `USBE_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Device register write strobe, software clears flags here
  assign wdec = decode(awaddr_reg);
  assign regs.reg_wr = do_write && wlane_reg && wdec != 3'h0;
  assign regs.reg_wsel = wdec[1:0];
  assign regs.reg_wdata = wbyte_reg;
  assign regs.forced_bus_reset = forced_bus_reset_reg;

  // Read: address taken, data one cycle later
  assign s_axi_arready = !rd_pend_reg && !s_axi_rvalid;
  assign regs.reg_rsel = araddr_reg[3:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_reg <= 1'b0;
      araddr_reg <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_pend_reg <= 1'b1;
      araddr_reg <= s_axi_araddr;
    end else begin
      rd_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `USBE_RESP_OKAY;
    end else if (rd_pend_reg) begin
      s_axi_rvalid <= 1'b1;
      if (decode(araddr_reg) != 3'h0) begin
        s_axi_rdata <= {24'h000000, regs.reg_rdata};
        s_axi_rresp <= `USBE_RESP_OKAY;
      end else if (araddr_reg == `USBE_OFF_CTRL) begin
        s_axi_rdata <= {31'h00000000, forced_bus_reset_reg};
        s_axi_rresp <= `USBE_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `USBE_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// *** tb/usbe_endpoint12_sva.sv ***
`timescale 1ns/1ns
module usbe_endpoint12_sva
  import usbe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reg_wr,
  input wire logic [1:0] reg_wsel,
  input wire usbe_byte_t reg_wdata,
  input wire logic [1:0] reg_rsel,
  input wire usbe_byte_t reg_rdata,
  input wire logic forced_bus_reset
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ep1_upper_zero_a: assert property (reg_rsel == 2'h0 |-> reg_rdata[7:4] == 4'h0)
    else $error("ep1 rx upper bits not zero");
  ep2_gap_zero_a: assert property (reg_rsel == 2'h2 |-> reg_rdata[5:4] == 2'h0)
    else $error("ep2 rx bits 5:4 not zero");
  usb_reset_clear_a: assert property (forced_bus_reset |=> reg_rdata[2:0] == 3'h0)
    else $error("sequence or status kept under usb reset");
  mode_source_a: assert property (reg_rsel == 2'h2 && $past(reg_rsel) == 2'h2 &&
    reg_rdata[7:6] != $past(reg_rdata[7:6]) |-> reg_rdata[7:6] == 2'h0 ||
    ($past(reg_wr) && $past(reg_wsel) == 2'h2 && reg_rdata[7:6] == $past(reg_wdata[7:6])))
    else $error("mode changed without cause");
  mode_three_a: assert property (reg_wr && reg_wsel == 2'h2 && reg_wdata[7:6] == 2'h3
    |=> reg_rsel != 2'h2 || reg_rdata[7:6] == 2'h3)
    else $error("mode three not kept");
  seq_write_a: assert property (reg_wr && reg_wsel == 2'h1 && !forced_bus_reset
    |=> reg_rsel != 2'h1 || reg_rdata[2] == $past(reg_wdata[2]))
    else $error("sequence write lost");
  stat_write_a: assert property (reg_wr && reg_wsel == 2'h0 && !forced_bus_reset
    ##1 reg_rsel == 2'h0 |-> reg_rdata[1:0] == $past(reg_wdata[1:0]))
    else $error("status write lost");
  dl_stat_lock_a: assert property (reg_wr && reg_wsel == 2'h2 && reg_rsel == 2'h2 &&
    reg_rdata[7:6] == 2'h2 && reg_wdata[1:0] == 2'h1 |=> reg_rdata[1:0] != 2'h1)
    else $error("download status write not blocked");
endmodule

// *** tb/usbe_endpoint12_control_tb_top.sv ***
`timescale 1ns/1ns
`include "usbe_consts.svh"
module usbe_endpoint12_control_tb_top;
  import usbe_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, evt_ep = 2'h0;
  logic evt_valid = 1'h0, evt_in = 1'h0, evt_ok = 1'h0, evt_data1 = 1'h0, evt_ack = 1'h0;
  logic evt_short = 1'h0, buf_rx_ready = 1'h0, buf_tx_ready = 1'h0, bus_reset_in = 1'h0;
  logic [7:0] row_a [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08};
  logic [7:0] row_d [10] = '{8'h00, 8'h01, 8'h02, 8'hF7, 8'h01, 8'h02, 8'h06, 8'h35, 8'hC0, 8'h00};
  logic [7:0] row_e [10] = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h01, 8'h02, 8'h06, 8'h05, 8'hC0, 8'h00};
  logic [31:0] d;
  logic [1:0] r;
  logic [1:0] mode_out;
  usbe_field_t f1r, f1t, f2r, f2t;
  int n_fail = 0, cmp_count = 0;

  usbe_reg_if link();
  usbe_endpoint_dev usbe_endpoint_dev_inst (.aclk(aclk), .aresetn(aresetn), .regs(link.dev),
    .bus_reset_in(bus_reset_in), .evt_valid(evt_valid), .evt_ep(evt_ep), .evt_in(evt_in),
    .evt_ok(evt_ok), .evt_data1(evt_data1), .evt_ack(evt_ack), .evt_short(evt_short),
    .buf_rx_ready(buf_rx_ready), .buf_tx_ready(buf_tx_ready), .ep1_rx_field(f1r),
    .ep1_tx_field(f1t), .ep2_rx_field(f2r), .ep2_tx_field(f2t), .ep2_mode(mode_out));
  usbe_sw_ctl usbe_sw_ctl_inst (.aclk(aclk), .aresetn(aresetn), .regs(link.ctl),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1));
  usbe_endpoint12_sva usbe_endpoint12_sva_inst (.aclk(aclk), .aresetn(aresetn),
    .reg_wr(link.reg_wr), .reg_wsel(link.reg_wsel), .reg_wdata(link.reg_wdata),
    .reg_rsel(link.reg_rsel), .reg_rdata(link.reg_rdata),
    .forced_bus_reset(link.forced_bus_reset));

  always #5 aclk = ~aclk;

  task automatic close_out;
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
    int n;
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) break;
    end
    if (n == 50) begin
      n_fail++;
      close_out();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
      if (tr) break;
    end
    if (n == 50) begin
      n_fail++;
      close_out();
    end
  endtask

  task automatic wc(input logic [7:0] a, input logic [7:0] v);
    logic [1:0] rs;
    wr(a, v, rs);
    chk({30'h0, rs}, {30'h0, `USBE_RESP_OKAY});
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    chk(v, {24'h0, e});
    chk({30'h0, rs}, {30'h0, `USBE_RESP_OKAY});
  endtask

  task automatic ev(input logic [1:0] ep, input logic i, ok, d1, ak, sh);
    evt_ep <= ep;
    evt_in <= i;
    evt_ok <= ok;
    evt_data1 <= d1;
    evt_ack <= ak;
    evt_short <= sh;
    evt_valid <= 1'h1;
    @(posedge aclk);
    evt_valid <= 1'h0;
    @(posedge aclk);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) rc(8'(i * 4), 8'h00);
    for (int i = 0; i < 10; i++) begin
      wc(row_a[i], row_d[i]);
      rc(row_a[i], row_e[i]);
    end
    wc(`USBE_OFF_EP1_RX, 8'h03);
    ev(2'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    rc(`USBE_OFF_EP1_RX, 8'h0E);
    wc(`USBE_OFF_EP1_RX, 8'h07);
    ev(2'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    ev(2'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    rc(`USBE_OFF_EP1_RX, 8'h07);
    wc(`USBE_OFF_EP1_TX, 8'h03);
    ev(2'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
    rc(`USBE_OFF_EP1_TX, 8'h0E);
    ev(2'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
    rc(`USBE_OFF_EP1_TX, 8'h0E);
    wc(`USBE_OFF_CTRL, 8'h01);
    wc(`USBE_OFF_CTRL, 8'h00);
    rc(`USBE_OFF_EP1_TX, 8'h08);
    wc(`USBE_OFF_EP1_RX, 8'h07);
    bus_reset_in <= 1'h1;
    @(posedge aclk);
    bus_reset_in <= 1'h0;
    @(posedge aclk);
    rc(`USBE_OFF_EP1_RX, 8'h00);
    wr(8'h14, 8'hFF, r);
    chk({30'h0, r}, {30'h0, `USBE_RESP_SLVERR});
    rd(8'h14, d, r);
    chk({d[29:0], r}, {30'h0, `USBE_RESP_SLVERR});
    wc(`USBE_OFF_EP2_RX, 8'h83);
    ev(2'h2, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    rc(`USBE_OFF_EP2_RX, 8'h86);
    wc(`USBE_OFF_EP2_RX, 8'h85);
    rc(`USBE_OFF_EP2_RX, 8'h86);
    wc(`USBE_OFF_EP2_TX, 8'h03);
    ev(2'h2, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
    rc(`USBE_OFF_EP2_TX, 8'h0E);
    buf_rx_ready <= 1'h1;
    @(posedge aclk);
    buf_rx_ready <= 1'h0;
    rc(`USBE_OFF_EP2_RX, 8'h87);
    ev(2'h2, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
    rc(`USBE_OFF_EP2_RX, 8'h0A);
    wc(`USBE_OFF_EP2_TX, 8'h02);
    wc(`USBE_OFF_EP2_RX, 8'h40);
    wc(`USBE_OFF_EP2_TX, 8'h01);
    rc(`USBE_OFF_EP2_TX, 8'h02);
    buf_tx_ready <= 1'h1;
    @(posedge aclk);
    buf_tx_ready <= 1'h0;
    rc(`USBE_OFF_EP2_TX, 8'h03);
    ev(2'h2, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
    rc(`USBE_OFF_EP2_TX, 8'h06);
    rc(`USBE_OFF_EP2_RX, 8'h40);
    chk({14'h0, mode_out, f2t, f2r, f1t, f1r}, 32'h00016080);
    buf_tx_ready <= 1'h1;
    @(posedge aclk);
    buf_tx_ready <= 1'h0;
    ev(2'h2, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1);
    rc(`USBE_OFF_EP2_TX, 8'h0A);
    rc(`USBE_OFF_EP2_RX, 8'h00);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) rc(8'(i * 4), 8'h00);
    close_out();
  end
endmodule
